// >>> hw/vmx_ctl_pkg.sv
package vmx_ctl_pkg;
  // register word offsets
  localparam logic [3:0] OFS_ASYNC = 4'h0;
  localparam logic [3:0] OFS_INSTR = 4'h1;
  localparam logic [3:0] OFS_ACAP0 = 4'h2; // async must-be-one mask
  localparam logic [3:0] OFS_ACAP1 = 4'h3; // async may-be-one mask
  localparam logic [3:0] OFS_ICAP0 = 4'h4;
  localparam logic [3:0] OFS_ICAP1 = 4'h5;
  localparam logic [3:0] OFS_ENTRY = 4'h6; // write: entry request
  localparam logic [3:0] OFS_STAT = 4'h7;
  localparam logic [3:0] OFS_MASK = 4'h8;
  // async bit positions
  localparam int B_EXT = 0;
  localparam int B_NMI = 3;
  // instruction bit positions
  localparam int B_IWIN = 2;
  localparam int B_TSOFS = 3;
  localparam int B_HLT = 7;
  localparam int B_INVP = 9;
  localparam int B_MWT = 10;
  localparam int B_PMC = 11;
  localparam int B_TSR = 12;
  localparam int B_TPW = 19;
  localparam int B_TPR = 20;
  localparam int B_TSH = 21;
  localparam int B_DRM = 23;
  localparam int B_UIO = 24;
  localparam int B_IOBM = 25;
  localparam int B_MSBM = 28;
  localparam int B_MON = 29;
  localparam int B_PAU = 30;
  // reset values and capabilities
  localparam logic [31:0] ASYNC_RST = 32'h0000_0016;
  localparam logic [31:0] INSTR_RST = 32'h0401_e172;
  localparam logic [31:0] ACAP0_DEF = 32'h0000_0016;
  localparam logic [31:0] ACAP1_DEF = 32'h0000_001f;
  localparam logic [31:0] ICAP0_DEF = 32'h0401_e172;
  localparam logic [31:0] ICAP1_DEF = 32'h77bb_fffe;
  // instruction classes
  typedef enum logic [3:0] {
    IC_NONE = 4'h0, IC_HLT = 4'h1, IC_INVP = 4'h2, IC_MWT = 4'h3,
    IC_PMC = 4'h4, IC_TSR = 4'h5, IC_TPW = 4'h6, IC_TPR = 4'h7,
    IC_DRM = 4'h8, IC_IO = 4'h9, IC_MSR = 4'ha, IC_MON = 4'hb,
    IC_PAU = 4'hc
  } instr_class_e;
  // guest event request
  typedef struct packed {
    logic ext_irq;
    logic nmi;
    logic if_flag;
    logic other_block;
    logic instr_valid;
    instr_class_e instr;
    logic io_bitmap_hit;
    logic msr_bitmap_hit;
  } guest_req_s;
  // decision result
  typedef struct packed {
    logic exit;
    logic deliver_ext;
    logic deliver_nmi;
    logic ts_offset;
    logic tpr_shadow;
    logic ext_blocked;
  } decision_s;
endpackage

// >>> hw/vm_exit_control_decode.sv
// The implementer's own choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/10ps
module vm_exit_control_decode
  import vmx_ctl_pkg::*;
#(
  parameter logic [31:0] ACAP0 = ACAP0_DEF,
  parameter logic [31:0] ACAP1 = ACAP1_DEF,
  parameter logic [31:0] ICAP0 = ICAP0_DEF,
  parameter logic [31:0] ICAP1 = ICAP1_DEF
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire guest_req_s req_i,
  output decision_s dec_o,
  output logic entry_fail_o,
  output logic irq_o
);
  logic [31:0] async_q, instr_q, stat_q, mask_q, rdata_q;
  logic ack_q, fail_q, irq_q, wait_q;
  decision_s dec_q;

  // bus decode
  wire access = avs_read_i | avs_write_i;
  wire wr_en = avs_write_i & ack_q;
  wire [31:0] bmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                       {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  wire [31:0] wmerge_a = (async_q & ~bmask) | (avs_writedata_i & bmask);
  wire [31:0] wmerge_i = (instr_q & ~bmask) | (avs_writedata_i & bmask);
  wire wr_async = wr_en & (avs_address_i == OFS_ASYNC);
  wire wr_instr = wr_en & (avs_address_i == OFS_INSTR);
  wire wr_entry = wr_en & (avs_address_i == OFS_ENTRY);
  wire wr_stat = wr_en & (avs_address_i == OFS_STAT);
  wire wr_mask = wr_en & (avs_address_i == OFS_MASK);

  // reserved bit check: fixed ones set, fixed zeros clear
  // reserved values
  wire async_bad = ((async_q & ACAP0) != ACAP0) | ((async_q & ~ACAP1) != '0);
  wire instr_bad = ((instr_q & ICAP0) != ICAP0) | ((instr_q & ~ICAP1) != '0);
  wire vec_bad = async_bad | instr_bad;

  // read mux
  logic [31:0] rd_mux;
  always_comb begin
    case (avs_address_i)
      OFS_ASYNC: rd_mux = async_q;
      OFS_INSTR: rd_mux = instr_q;
      OFS_ACAP0: rd_mux = ACAP0;
      OFS_ACAP1: rd_mux = ACAP1;
      OFS_ICAP0: rd_mux = ICAP0;
      OFS_ICAP1: rd_mux = ICAP1;
      OFS_ENTRY: rd_mux = {31'h0, fail_q};
      OFS_STAT: rd_mux = stat_q;
      OFS_MASK: rd_mux = mask_q;
      default: rd_mux = 32'h0;
    endcase
  end

  // one wait cycle, then ack
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_q <= 1'b0;
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
    end else begin
      ack_q <= access & ~ack_q;
      wait_q <= ~(access & ~ack_q); // low only in the ack cycle
      if (access & ~ack_q) begin
        rdata_q <= rd_mux;
      end
    end
  end
  assign avs_waitrequest_o = wait_q;
  assign avs_readdata_o = rdata_q;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      async_q <= ASYNC_RST;
      instr_q <= INSTR_RST;
      mask_q <= 32'h0;
    end else begin
      if (wr_async) async_q <= wmerge_a;
      if (wr_instr) instr_q <= wmerge_i;
      if (wr_mask) mask_q <= avs_writedata_i & 32'h3;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fail_q <= 1'b0;
    end else if (wr_entry) begin
      fail_q <= vec_bad;
    end
  end
  assign entry_fail_o = fail_q;

  // decode of guest events
  wire [31:0] iv = instr_q;
  wire ext_exit = async_q[B_EXT];
  wire ext_blk = ext_exit ? req_i.other_block
                          : (~req_i.if_flag | req_i.other_block);
  wire win_exit = iv[B_IWIN] & req_i.if_flag & ~req_i.other_block;
  wire io_exit = iv[B_IOBM] ? req_i.io_bitmap_hit : iv[B_UIO];
  wire msr_exit = iv[B_MSBM] ? req_i.msr_bitmap_hit : 1'b1;
  logic ins_exit;
  always_comb begin
    case (req_i.instr)
      IC_HLT: ins_exit = iv[B_HLT];
      IC_INVP: ins_exit = iv[B_INVP];
      IC_MWT: ins_exit = iv[B_MWT];
      IC_PMC: ins_exit = iv[B_PMC];
      IC_TSR: ins_exit = iv[B_TSR];
      IC_TPW: ins_exit = iv[B_TPW];
      IC_TPR: ins_exit = iv[B_TPR];
      IC_DRM: ins_exit = iv[B_DRM];
      IC_MON: ins_exit = iv[B_MON];
      IC_PAU: ins_exit = iv[B_PAU];
      IC_IO: ins_exit = io_exit;
      IC_MSR: ins_exit = msr_exit;
      default: ins_exit = 1'b0;
    endcase
  end
  wire instr_exit = req_i.instr_valid & (ins_exit | win_exit);
  wire ext_ev = req_i.ext_irq & ~ext_blk;
  wire nmi_ev = req_i.nmi;
  decision_s dec_d;
  always_comb begin
    dec_d.exit = instr_exit | (ext_ev & ext_exit) | (nmi_ev & async_q[B_NMI]);
    dec_d.deliver_ext = ext_ev & ~ext_exit;
    dec_d.deliver_nmi = nmi_ev & ~async_q[B_NMI];
    dec_d.ts_offset = iv[B_TSOFS];
    dec_d.tpr_shadow = iv[B_TSH];
    dec_d.ext_blocked = ext_blk;
  end

  // registered decision
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) dec_q <= '0;
    else dec_q <= dec_d;
  end
  assign dec_o = dec_q;

  // sticky status: bit0 exit, bit1 entry fail; set wins over clear
  wire [31:0] ev = {30'h0, wr_entry & vec_bad, dec_d.exit};
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stat_q <= 32'h0;
      irq_q <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~(wr_stat ? avs_writedata_i : 32'h0)) | ev;
      irq_q <= |(((stat_q & ~(wr_stat ? avs_writedata_i : 32'h0)) | ev)
                 & mask_q);
    end
  end
  assign irq_o = irq_q;

  property p_nmi;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (req_i.nmi && async_q[B_NMI]) |=> dec_o.exit && !dec_o.deliver_nmi;
  endproperty
  AST_NMI_EXIT: assert property (p_nmi) else $error("nmi no exit");
  AST_EXT_EXIT: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (req_i.ext_irq && !req_i.other_block && async_q[B_EXT])
    |=> dec_o.exit && !dec_o.deliver_ext) else $error("ext no exit");
  AST_IF_IGN: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (async_q[B_EXT] && !req_i.other_block) |=> !dec_o.ext_blocked)
    else $error("flag blocked");
  AST_HLT: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (req_i.instr_valid && req_i.instr == IC_HLT && iv[B_HLT]) |=> dec_o.exit)
    else $error("halt no exit");
  AST_TSR: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (req_i.instr_valid && req_i.instr == IC_TSR && iv[B_TSR]) |=> dec_o.exit)
    else $error("ts read no exit");
  AST_IO_BM: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (req_i.instr_valid && req_i.instr == IC_IO && iv[B_IOBM]
     && !req_i.io_bitmap_hit && !win_exit) |=> !dec_o.exit)
    else $error("io bitmap ignored");
  AST_MSR_ALL: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (req_i.instr_valid && req_i.instr == IC_MSR && !iv[B_MSBM])
    |=> dec_o.exit) else $error("msr no exit");
  sequence s_entry_bad;
    wr_entry && vec_bad;
  endsequence
  AST_ENTRY: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    s_entry_bad |=> entry_fail_o ##1 stat_q[1])
    else $error("bad entry passed");
  AST_WAIT: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (access && avs_waitrequest_o) |=> !avs_waitrequest_o)
    else $error("no ack");

  // no other exit source, so a clear control must give no exit
  wire quiet = !win_exit & !req_i.ext_irq & !req_i.nmi;

  AST_EXT_PASS: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (req_i.ext_irq && !async_q[B_EXT] && !ext_blk) |=> dec_o.deliver_ext)
    else $error("ext not delivered");

  AST_EXT_BLK: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (!async_q[B_EXT] && !req_i.if_flag) |=> dec_o.ext_blocked)
    else $error("flag ignored");

  AST_NMI_PASS: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (req_i.nmi && !async_q[B_NMI]) |=> dec_o.deliver_nmi)
    else $error("nmi not delivered");

  AST_RSV_OK: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (wr_entry && !vec_bad) |=> !entry_fail_o)
    else $error("good entry failed");

  AST_WIN: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (req_i.instr_valid && iv[B_IWIN] && req_i.if_flag
     && !req_i.other_block) |=> dec_o.exit) else $error("no window exit");

  AST_TSOFS: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    iv[B_TSOFS] |=> dec_o.ts_offset)
    else $error("offset not selected");

  AST_TSOFS_OFF: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    !iv[B_TSOFS] |=> !dec_o.ts_offset)
    else $error("offset selected");

  AST_INVP: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (req_i.instr_valid && req_i.instr == IC_INVP && iv[B_INVP]) |=> dec_o.exit)
    else $error("invalidate no exit");

  AST_MWT: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (req_i.instr_valid && req_i.instr == IC_MWT && iv[B_MWT]) |=> dec_o.exit)
    else $error("wait no exit");

  AST_HLT_OFF: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (req_i.instr == IC_HLT && !iv[B_HLT] && quiet) |=> !dec_o.exit)
    else $error("halt exit when clear");

  AST_PMC: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (req_i.instr_valid && req_i.instr == IC_PMC && iv[B_PMC]) |=> dec_o.exit)
    else $error("counter read no exit");

  AST_PMC_OFF: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (req_i.instr == IC_PMC && !iv[B_PMC] && quiet) |=> !dec_o.exit)
    else $error("counter read exit when clear");

  AST_DRM: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (req_i.instr_valid && req_i.instr == IC_DRM && iv[B_DRM]) |=> dec_o.exit)
    else $error("debug move no exit");

  AST_MON: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (req_i.instr_valid && req_i.instr == IC_MON && iv[B_MON]) |=> dec_o.exit)
    else $error("monitor no exit");

  AST_PAU: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (req_i.instr_valid && req_i.instr == IC_PAU && iv[B_PAU]) |=> dec_o.exit)
    else $error("pause no exit");

  AST_TPW: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (req_i.instr_valid && req_i.instr == IC_TPW && iv[B_TPW]) |=> dec_o.exit)
    else $error("priority write no exit");

  AST_TPR: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (req_i.instr_valid && req_i.instr == IC_TPR && iv[B_TPR]) |=> dec_o.exit)
    else $error("priority read no exit");

  AST_TSH: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    iv[B_TSH] |=> dec_o.tpr_shadow)
    else $error("shadow not active");

  AST_UIO: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (req_i.instr_valid && req_i.instr == IC_IO && iv[B_UIO] && !iv[B_IOBM])
    |=> dec_o.exit) else $error("port io no exit");

  AST_UIO_OFF: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (req_i.instr == IC_IO && !iv[B_UIO] && !iv[B_IOBM] && quiet)
    |=> !dec_o.exit) else $error("port io exit when clear");

  AST_MSR_BM: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (req_i.instr_valid && req_i.instr == IC_MSR && req_i.msr_bitmap_hit)
    |=> dec_o.exit) else $error("msr hit no exit");

  AST_RETIRE: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (!req_i.instr_valid && !req_i.ext_irq && !req_i.nmi) |=> !dec_o.exit)
    else $error("exit without event");
endmodule

// >>> bench/testbench.sv
`timescale 1ns/10ps
module testbench;
  import vmx_ctl_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic wait_o;
  guest_req_s rq = '0;
  guest_req_s r;
  decision_s dec;
  logic efail;
  logic irq;
  logic [31:0] v;
  int n_fail = 0;
  int n_tests = 0;
  instr_class_e cls [10] = '{IC_HLT, IC_INVP, IC_MWT, IC_PMC, IC_TSR,
    IC_TPW, IC_TPR, IC_DRM, IC_MON, IC_PAU};
  int pos [10] = '{B_HLT, B_INVP, B_MWT, B_PMC, B_TSR, B_TPW, B_TPR, B_DRM,
    B_MON, B_PAU};

  vm_exit_control_decode dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdat), .avs_byteenable_i(4'hf), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wait_o), .req_i(rq), .dec_o(dec),
    .entry_fail_o(efail), .irq_o(irq));

  // free running system clock
  always #50 clk_sys_i = ~clk_sys_i;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    adr <= a;
    wdat <= d;
    rd <= !w;
    wr <= w;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (wait_o !== 1'b0 && n < 50);
    v = rdat;
    if (n >= 50) n_fail++;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(v, e);
  endtask

  // apply a guest request and let the registered decision settle
  task automatic go(input guest_req_s g);
    @(posedge clk_sys_i);
    rq <= g;
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask

  function automatic guest_req_s mk(input instr_class_e c, input logic io,
                                    input logic ms);
    guest_req_s g;
    g = '0;
    g.instr_valid = 1'b1;
    g.instr = c;
    g.io_bitmap_hit = io;
    g.msr_bitmap_hit = ms;
    return g;
  endfunction

  task automatic report_and_stop;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // watchdog well beyond the expected few hundred cycles
  initial begin
    #2000000;
    n_fail++;
    report_and_stop();
  end

  initial begin
    repeat (6) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    rreg(OFS_ASYNC, ASYNC_RST);
    rreg(OFS_INSTR, INSTR_RST);
    rreg(OFS_ACAP0, ACAP0_DEF);
    rreg(OFS_ICAP1, ICAP1_DEF);
    rreg(4'h9, 32'h0);
    bus(1'b1, OFS_ICAP0, 32'h0);
    rreg(OFS_ICAP0, ICAP0_DEF);
    // each of the ten instruction exit bits in cls on and off
    for (int i = 0; i < 10; i++) begin
      bus(1'b1, OFS_INSTR, INSTR_RST | (32'h1 << pos[i]));
      go(mk(cls[i], 1'b0, 1'b0));
      chk(dec.exit, 1'b1);
      bus(1'b1, OFS_INSTR, INSTR_RST);
      go(mk(cls[i], 1'b0, 1'b0));
      chk(dec.exit, 1'b0);
    end
    bus(1'b1, OFS_INSTR, INSTR_RST | (32'h1 << B_UIO));
    go(mk(IC_IO, 1'b0, 1'b0));
    chk(dec.exit, 1'b1);
    bus(1'b1, OFS_INSTR, INSTR_RST | (32'h3 << B_UIO));
    go(mk(IC_IO, 1'b0, 1'b0));
    chk(dec.exit, 1'b0);
    go(mk(IC_IO, 1'b1, 1'b0));
    chk(dec.exit, 1'b1);
    bus(1'b1, OFS_INSTR, INSTR_RST);
    go(mk(IC_MSR, 1'b0, 1'b0));
    chk(dec.exit, 1'b1);
    bus(1'b1, OFS_INSTR, INSTR_RST | (32'h1 << B_MSBM));
    go(mk(IC_MSR, 1'b0, 1'b0));
    chk(dec.exit, 1'b0);
    go(mk(IC_MSR, 1'b0, 1'b1));
    chk(dec.exit, 1'b1);
    bus(1'b1, OFS_INSTR, INSTR_RST | 32'h0020_0008);
    go(mk(IC_NONE, 1'b0, 1'b0));
    chk({dec.ts_offset, dec.tpr_shadow}, 2'b11);
    // interrupt window exiting
    bus(1'b1, OFS_INSTR, INSTR_RST | (32'h1 << B_IWIN));
    r = mk(IC_NONE, 1'b0, 1'b0);
    r.if_flag = 1'b1;
    go(r);
    chk(dec.exit, 1'b1);
    r.other_block = 1'b1;
    go(r);
    chk(dec.exit, 1'b0);
    bus(1'b1, OFS_INSTR, INSTR_RST);
    // external interrupt and nmi paths
    r = '0;
    r.ext_irq = 1'b1;
    r.if_flag = 1'b1;
    go(r);
    chk({dec.exit, dec.deliver_ext}, 2'b01);
    r.if_flag = 1'b0;
    go(r);
    chk({dec.deliver_ext, dec.ext_blocked}, 2'b01);
    bus(1'b1, OFS_ASYNC, ASYNC_RST | 32'h1);
    go(r);
    chk({dec.exit, dec.ext_blocked}, 2'b10);
    r = '0;
    r.nmi = 1'b1;
    go(r);
    chk({dec.exit, dec.deliver_nmi}, 2'b01);
    bus(1'b1, OFS_ASYNC, ASYNC_RST | 32'h8);
    go(r);
    chk(dec.exit, 1'b1);
    // entry checks against fixed bits
    bus(1'b1, OFS_ASYNC, 32'h0000_0014);
    bus(1'b1, OFS_ENTRY, 32'h0);
    rreg(OFS_ENTRY, 32'h1);
    bus(1'b1, OFS_ASYNC, ASYNC_RST);
    bus(1'b1, OFS_INSTR, INSTR_RST | 32'h1);
    bus(1'b1, OFS_ENTRY, 32'h0);
    go('0);
    chk(efail, 1'b1);
    bus(1'b1, OFS_INSTR, INSTR_RST);
    bus(1'b1, OFS_ENTRY, 32'h0);
    go('0);
    chk(efail, 1'b0);
    // status, mask and interrupt line
    bus(1'b1, OFS_STAT, 32'h3);
    bus(1'b1, OFS_MASK, 32'h1);
    go(mk(IC_MSR, 1'b0, 1'b0));
    go('0);
    chk(irq, 1'b1);
    bus(1'b1, OFS_STAT, 32'h1);
    go('0);
    chk(irq, 1'b0);
    bus(1'b1, OFS_MASK, 32'h0);
    go(mk(IC_MSR, 1'b0, 1'b0));
    go('0);
    chk(irq, 1'b0);
    rreg(OFS_STAT, 32'h1);
    report_and_stop();
  end
endmodule
